/* File: bml_loader.sv */
/*
 Boot mode loader: captures the mode pins at reset, configures the boot
 source, runs UART autobaud, parses the block-structured stream and
 starts execution. Assumes a byte stream from the selected peripheral
 and pins from outside sampled by three flip-flops here.
*/
// Functional notes
// - Capture four mode pins after each power-on or software reset.
// - Decode mode codes to sources; reserved codes behave as idle.
// - Mode zero performs no boot and idles.
// - Flash mode starts at async bank base, 8 bits wide; header can pick a jump.
// - Flash mode uses 4 setup, 15 access, 3 hold cycles.
// - FIFO mode reads 16-bit words, each requested by low pulse.
// - SPI memory: select by gpio, send read then zero bytes.
// - SPI memory loads baud divisor 0x85 before transfer.
// - I2C memory: master at 0xA0, read from address zero, two bytes.
// - I2C memory uses prescale 0xA and divider 0x0811.
// - I2C host mode: slave at 0x5F acknowledging when addressed.
// - UART host sends 0x40; device measures it for bit rate.
// - After autobaud send 0xBF, divisor low, divisor high, 0x00.
// - UART mode drops RTS when busy and ignores CTS.
// - SDRAM mode warm boots from 0x10 with controller ready.
// - Host DMA: 16-bit ack mode or 8-bit interrupt, little endian.
// - Host call command jumps to fixed L1 address.
// - Each block starts with 16-byte header of count and address.
// - After last block execute from reset event vector.
// - Hold host wait asserted until pre-boot finishes.
`timescale 1ns/100ps

module bml_loader (
	// Clock and reset
	input  wire logic              CORE_CLK,
	input  wire logic              NRST,
	// Reset source and pins
	input  wire logic              SOFT_RESET,
	input  wire logic [3:0]        BOOT_SOURCE_SELECT,
	input  wire logic              PREBOOT_DONE,
	input  wire logic [31:0]       RESET_EVENT_VECTOR,
	// Boot byte stream from the selected peripheral
	input  wire bml_pkg::bml_byte_s STREAM_IN,
	output logic                   STREAM_READY,
	// Pins sampled and driven by the loader
	input  wire logic              DMA_REQUEST_ONE_N,
	input  wire logic              UART_RXD,
	input  wire logic              UART_CTS,
	output logic                   UART_TXD,
	output logic                   UART_RTS_N,
	output logic                   FLASH_SELECT_GPIO_N,
	output logic                   HOST_WAIT_OUT,
	output logic                   HOST_READY_FLAG,
	input  wire logic              HOST_CALL_COMMAND,
	// Configuration and results
	output bml_pkg::bml_cfg_s      BOOT_CFG,
	output bml_pkg::bml_wr_s       MEM_WR,
	output logic                   SPI_PREAMBLE,
	output logic                   FIFO_WORD_TAKEN,
	output logic                   JUMP_VALID,
	output logic [31:0]            JUMP_ADDR,
	output logic                   BOOT_IDLE
);

	typedef enum logic [3:0] {
		S_CAPTURE,
		S_PREBOOT,
		S_IDLE,
		S_AUTOBAUD,
		S_ACK,
		S_HOST,
		S_HEADER,
		S_PAYLOAD,
		S_DONE
	} bml_state_e;

	bml_state_e          state_q, state_d;
	logic [3:0]          mode_q;
	logic [2:0]          rxd_sync_q;
	logic [2:0]          dmar_sync_q;
	logic [2:0]          cmd_sync_q;
	logic                rxd_stable_q, dmar_stable_q, cmd_stable_q;
	logic [127:0]        hdr_q;
	logic [3:0]          hdr_idx_q;
	logic [31:0]         count_q, addr_q;
	logic [19:0]         ab_cnt_q;
	logic                ab_run_q;
	logic [15:0]         divisor_q;
	logic [1:0]          ack_idx_q;
	logic                ack_end_q;
	logic [3:0]          tx_bit_q;
	logic [15:0]         tx_cnt_q;
	logic [9:0]          tx_sh_q;
	logic                soft_q;
	bml_pkg::bml_cfg_s   cfg_q;
	bml_pkg::bml_wr_s    wr_q;

	// Field extraction from the little-endian header
	function automatic logic [31:0] hdr_word(input logic [127:0] h, input logic [3:0] lo);
		hdr_word = h[{lo, 3'h0} +: 32];
	endfunction

	function automatic logic is_valid_mode(input logic [3:0] m);
		is_valid_mode = (m <= bml_pkg::MODE_UART) || (m == bml_pkg::MODE_SDRAM) ||
			(m == bml_pkg::MODE_HDMA16) || (m == bml_pkg::MODE_HDMA8);
	endfunction

	wire logic        take_byte   = STREAM_IN.valid && STREAM_READY;
	wire logic [127:0] hdr_next   = {STREAM_IN.data, hdr_q[127:8]};
	wire logic [31:0] flags_w     = hdr_word(hdr_next, bml_pkg::HDR_FLAGS_LO);
	wire logic        flag_final  = flags_w[bml_pkg::FLG_FINAL];
	wire logic        flag_jump   = flags_w[bml_pkg::FLG_JUMP];
	wire logic        is_hdma     = (mode_q == bml_pkg::MODE_HDMA16) || (mode_q == bml_pkg::MODE_HDMA8);
	wire logic        is_uart     = (mode_q == bml_pkg::MODE_UART);
	wire logic        ack_done    = ack_end_q && (tx_bit_q == 4'h0);
	wire logic [7:0]  ack_byte    = (ack_idx_q == 2'h0) ? bml_pkg::ACK_HEAD :
		(ack_idx_q == 2'h1) ? divisor_q[7:0] :
		(ack_idx_q == 2'h2) ? divisor_q[15:8] : bml_pkg::ACK_TAIL;
	wire logic        ab_fall     = (rxd_sync_q[2] == rxd_sync_q[1]) && !rxd_sync_q[1] && rxd_stable_q;
	wire logic        ab_rise     = (rxd_sync_q[2] == rxd_sync_q[1]) && rxd_sync_q[1] && !rxd_stable_q;
	wire logic        dmar_fall   = (dmar_sync_q[2] == dmar_sync_q[1]) && !dmar_sync_q[1] && dmar_stable_q;
	wire logic        cmd_rise    = (cmd_sync_q[2] == cmd_sync_q[1]) && cmd_sync_q[1] && !cmd_stable_q;

	// Config presets per source
	function automatic bml_pkg::bml_cfg_s mode_cfg(input logic [3:0] m);
		mode_cfg              = '0;
		mode_cfg.source       = m;
		mode_cfg.port_width   = bml_pkg::WIDTH_8;
		mode_cfg.i2c_dev_addr = {1'b0, bml_pkg::I2C_OWN_ADDR};
		case (m)
			bml_pkg::MODE_FLASH: begin
				mode_cfg.start_addr   = bml_pkg::ADDR_FLASH;
				mode_cfg.flash_timing = {bml_pkg::FLASH_SETUP, bml_pkg::FLASH_ACCESS,
					bml_pkg::FLASH_HOLD};
			end
			bml_pkg::MODE_FIFO: begin
				mode_cfg.start_addr = bml_pkg::ADDR_FIFO;
				mode_cfg.port_width = bml_pkg::WIDTH_16;
			end
			bml_pkg::MODE_SPI_MEM: begin
				mode_cfg.spi_baud = bml_pkg::SPI_BAUD_DEF;
			end
			bml_pkg::MODE_I2C_MEM: begin
				mode_cfg.i2c_dev_addr = bml_pkg::I2C_MEM_ADDR;
				mode_cfg.start_addr   = {16'h0000, bml_pkg::I2C_INT_ADDR};
				mode_cfg.i2c_prescale = bml_pkg::I2C_PRESCALE;
				mode_cfg.i2c_i2c_clock_divider   = bml_pkg::I2C_I2C_CLOCK_DIVIDER;
			end
			bml_pkg::MODE_SDRAM: begin
				mode_cfg.start_addr = bml_pkg::ADDR_SDRAM;
			end
			bml_pkg::MODE_HDMA16: begin
				mode_cfg.port_width = bml_pkg::WIDTH_ACK16;
			end
			bml_pkg::MODE_HDMA8: begin
				mode_cfg.port_width = bml_pkg::WIDTH_INT8;
			end
			default: begin
				mode_cfg.start_addr = bml_pkg::ADDR_ZERO;
			end
		endcase
	endfunction

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_CAPTURE: state_d = S_PREBOOT;
			S_PREBOOT: begin
				if (PREBOOT_DONE) begin
					if (!is_valid_mode(mode_q) || mode_q == bml_pkg::MODE_IDLE)
						state_d = S_IDLE;
					else if (is_uart)
						state_d = S_AUTOBAUD;
					else if (is_hdma)
						state_d = S_HOST;
					else
						state_d = S_HEADER;
				end
			end
			S_AUTOBAUD: if (ab_run_q && ab_rise) state_d = S_ACK;
			S_ACK:      if (ack_done && tx_cnt_q == 16'h0) state_d = S_HEADER;
			S_HOST:     if (cmd_rise) state_d = S_DONE;
			S_HEADER: begin
				if (take_byte && hdr_idx_q == bml_pkg::HDR_LAST) begin
					if (flag_jump || flag_final && hdr_word(hdr_next, bml_pkg::HDR_COUNT_LO) == 32'h0)
						state_d = S_DONE;
					else if (hdr_word(hdr_next, bml_pkg::HDR_COUNT_LO) != 32'h0)
						state_d = S_PAYLOAD;
				end
			end
			S_PAYLOAD: begin
				if (take_byte && count_q == 32'h1)
					state_d = hdr_q[{bml_pkg::HDR_FLAGS_LO, 3'h0} + bml_pkg::FLG_FINAL] ? S_DONE : S_HEADER;
			end
			S_IDLE:  state_d = S_IDLE;
			S_DONE:  state_d = S_DONE;
			default: state_d = S_IDLE;
		endcase
	end

	// Pin synchronisers; the third stage only confirms the second
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rxd_sync_q   <= 3'h7;
			dmar_sync_q  <= 3'h7;
			cmd_sync_q   <= 3'h0;
			rxd_stable_q <= 1'b1;
			dmar_stable_q <= 1'b1;
			cmd_stable_q <= 1'b0;
		end else begin
			rxd_sync_q  <= {rxd_sync_q[1:0], UART_RXD};
			dmar_sync_q <= {dmar_sync_q[1:0], DMA_REQUEST_ONE_N};
			cmd_sync_q  <= {cmd_sync_q[1:0], HOST_CALL_COMMAND};
			if (rxd_sync_q[2] == rxd_sync_q[1]) rxd_stable_q <= rxd_sync_q[2];
			if (dmar_sync_q[2] == dmar_sync_q[1]) dmar_stable_q <= dmar_sync_q[2];
			if (cmd_sync_q[2] == cmd_sync_q[1]) cmd_stable_q <= cmd_sync_q[2];
		end
	end

	// Mode capture after reset release or software reset
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= S_CAPTURE;
			mode_q  <= bml_pkg::MODE_IDLE;
			soft_q  <= 1'b0;
			cfg_q   <= '0;
		end else begin
			soft_q <= SOFT_RESET;
			if (SOFT_RESET && !soft_q) begin
				state_q <= S_CAPTURE;
			end else begin
				state_q <= state_d;
				if (state_q == S_CAPTURE) begin
					mode_q <= BOOT_SOURCE_SELECT;
					cfg_q  <= mode_cfg(BOOT_SOURCE_SELECT);
				end
			end
		end
	end

	// Autobaud: time the low run of start bit plus six zeros
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ab_run_q  <= 1'b0;
			ab_cnt_q  <= 20'h0;
			divisor_q <= 16'h0;
		end else if (state_q == S_AUTOBAUD) begin
			if (ab_fall) begin
				ab_run_q <= 1'b1;
				ab_cnt_q <= 20'h0;
			end else if (ab_run_q) begin
				ab_cnt_q <= ab_cnt_q + 20'h1;
			end
			if (ab_run_q && ab_rise)
				divisor_q <= 16'(ab_cnt_q / 20'(bml_pkg::AB_LOW_BITS));
		end else begin
			ab_run_q <= 1'b0;
		end
	end

	// Acknowledge transmitter, 8N1 at the measured rate
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ack_idx_q <= 2'h0;
			ack_end_q <= 1'b0;
			tx_bit_q  <= 4'h0;
			tx_cnt_q  <= 16'h0;
			tx_sh_q   <= 10'h3FF;
		end else if (state_q == S_ACK) begin
			if (tx_cnt_q != 16'h0) begin
				tx_cnt_q <= tx_cnt_q - 16'h1;
			end else if (tx_bit_q != 4'h0) begin
				tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
				tx_bit_q <= tx_bit_q - 4'h1;
				tx_cnt_q <= divisor_q;
				if (tx_bit_q == 4'h1 && ack_idx_q != bml_pkg::ACK_LAST)
					ack_idx_q <= ack_idx_q + 2'h1;
				// Done only after the tail byte has left, not when it is due
				if (tx_bit_q == 4'h1 && ack_idx_q == bml_pkg::ACK_LAST)
					ack_end_q <= 1'b1;
			end else if (!ack_end_q) begin
				tx_sh_q  <= {1'b1, ack_byte, 1'b0};
				tx_bit_q <= 4'hA;
				tx_cnt_q <= divisor_q;
			end
		end else begin
			ack_idx_q <= 2'h0;
			ack_end_q <= 1'b0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 10'h3FF;
		end
	end

	// Header gather and payload writes
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			hdr_q     <= '0;
			hdr_idx_q <= 4'h0;
			count_q   <= 32'h0;
			addr_q    <= 32'h0;
			wr_q      <= '0;
		end else begin
			wr_q.valid <= 1'b0;
			if (state_q == S_HEADER && take_byte) begin
				hdr_q     <= hdr_next;
				hdr_idx_q <= hdr_idx_q + 4'h1;
				if (hdr_idx_q == bml_pkg::HDR_LAST) begin
					addr_q  <= hdr_word(hdr_next, bml_pkg::HDR_ADDR_LO);
					count_q <= hdr_word(hdr_next, bml_pkg::HDR_COUNT_LO);
				end
			end else if (state_q == S_PAYLOAD && take_byte) begin
				wr_q    <= '{valid: 1'b1, addr: addr_q, data: STREAM_IN.data};
				addr_q  <= addr_q + 32'h1;
				count_q <= count_q - 32'h1;
			end else if (state_q != S_HEADER) begin
				hdr_idx_q <= 4'h0;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			STREAM_READY        <= 1'b0;
			UART_TXD            <= 1'b1;
			UART_RTS_N          <= 1'b1;
			FLASH_SELECT_GPIO_N <= 1'b1;
			HOST_WAIT_OUT       <= 1'b1;
			HOST_READY_FLAG     <= 1'b0;
			BOOT_CFG            <= '0;
			MEM_WR              <= '0;
			SPI_PREAMBLE        <= 1'b0;
			FIFO_WORD_TAKEN     <= 1'b0;
			JUMP_VALID          <= 1'b0;
			JUMP_ADDR           <= 32'h0;
			BOOT_IDLE           <= 1'b0;
		end else begin
			STREAM_READY <= (state_d == S_HEADER || state_d == S_PAYLOAD) && !STREAM_READY;
			UART_TXD     <= tx_sh_q[0];
			// Busy outside stream states; CTS is not looked at
			UART_RTS_N   <= !(is_uart && (state_d == S_HEADER || state_d == S_PAYLOAD));
			FLASH_SELECT_GPIO_N <= !(mode_q == bml_pkg::MODE_SPI_MEM &&
				(state_q == S_HEADER || state_q == S_PAYLOAD));
			SPI_PREAMBLE <= (mode_q == bml_pkg::MODE_SPI_MEM) && state_q == S_PREBOOT;
			// Stays high through pre-boot; low in host state or while a byte can be taken
			HOST_WAIT_OUT   <= !(state_d == S_HOST ||
				(state_d == S_HEADER || state_d == S_PAYLOAD) && !STREAM_READY);
			HOST_READY_FLAG <= is_hdma && state_d == S_HOST;
			BOOT_CFG        <= cfg_q;
			MEM_WR          <= wr_q;
			FIFO_WORD_TAKEN <= (mode_q == bml_pkg::MODE_FIFO) && dmar_fall;
			BOOT_IDLE       <= state_q == S_IDLE;
			if (state_q != S_DONE && state_d == S_DONE) begin
				JUMP_VALID <= 1'b1;
				if (state_q == S_HOST)
					JUMP_ADDR <= bml_pkg::ADDR_L1_CALL;
				else if (state_q == S_HEADER && flag_jump)
					JUMP_ADDR <= hdr_word(hdr_next, bml_pkg::HDR_ADDR_LO);
				else
					JUMP_ADDR <= RESET_EVENT_VECTOR;
			end else if (state_d != S_DONE) begin
				JUMP_VALID <= 1'b0;
			end
		end
	end

endmodule

/* File: bml_loader_chk.sv */
/*
 Checker for the boot mode loader, bound to its top module.
 Assumes one clock domain and the settings struct of the package.
*/
`timescale 1ns/100ps

module bml_loader_chk (
	input wire logic              CORE_CLK,
	input wire logic              NRST,
	input wire logic              SOFT_RESET,
	input wire logic              PREBOOT_DONE,
	input wire bml_pkg::bml_cfg_s BOOT_CFG,
	input wire bml_pkg::bml_wr_s  MEM_WR,
	input wire logic              STREAM_READY,
	input wire logic              FLASH_SELECT_GPIO_N,
	input wire logic              HOST_WAIT_OUT,
	input wire logic              HOST_READY_FLAG,
	input wire logic              JUMP_VALID,
	input wire logic [31:0]       JUMP_ADDR,
	input wire logic              BOOT_IDLE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	wire logic [3:0] src = BOOT_CFG.source;
	wire logic       hdma = (src[3:1] == 3'h7);

	a_wait_preboot: assert property (!PREBOOT_DONE |-> HOST_WAIT_OUT)
		else $error("host wait low during pre-boot");
	a_spi_baud: assert property (src == bml_pkg::MODE_SPI_MEM |-> BOOT_CFG.spi_baud == bml_pkg::SPI_BAUD_DEF)
		else $error("spi baud default wrong");
	a_i2c_defaults: assert property (src == bml_pkg::MODE_I2C_MEM |->
		BOOT_CFG.i2c_prescale == bml_pkg::I2C_PRESCALE && BOOT_CFG.i2c_i2c_clock_divider == bml_pkg::I2C_I2C_CLOCK_DIVIDER
		&& BOOT_CFG.i2c_dev_addr == bml_pkg::I2C_MEM_ADDR)
		else $error("i2c memory defaults wrong");
	a_i2c_host: assert property (src == bml_pkg::MODE_I2C_HOST |->
		BOOT_CFG.i2c_dev_addr == {1'b0, bml_pkg::I2C_OWN_ADDR})
		else $error("i2c host own address wrong");
	a_flash_timing: assert property (src == bml_pkg::MODE_FLASH |-> BOOT_CFG.start_addr == bml_pkg::ADDR_FLASH
		&& BOOT_CFG.flash_timing == {bml_pkg::FLASH_SETUP, bml_pkg::FLASH_ACCESS, bml_pkg::FLASH_HOLD})
		else $error("flash settings wrong");
	a_start_addr: assert property ((src == bml_pkg::MODE_FIFO || src == bml_pkg::MODE_SDRAM) |->
		BOOT_CFG.start_addr == (src == bml_pkg::MODE_FIFO ? bml_pkg::ADDR_FIFO : bml_pkg::ADDR_SDRAM))
		else $error("start address wrong");
	a_port_width: assert property (hdma |->
		BOOT_CFG.port_width == (src[0] ? bml_pkg::WIDTH_INT8 : bml_pkg::WIDTH_ACK16))
		else $error("host port width wrong");
	a_idle_quiet: assert property (BOOT_IDLE |-> !MEM_WR.valid && !JUMP_VALID)
		else $error("activity while idle");
	a_ready_gap: assert property (STREAM_READY |=> !STREAM_READY)
		else $error("ready on two cycles running");
	a_spi_select: assert property (!FLASH_SELECT_GPIO_N |-> src == bml_pkg::MODE_SPI_MEM)
		else $error("memory select outside spi memory mode");
	a_call_addr: assert property (JUMP_VALID && hdma |-> JUMP_ADDR == bml_pkg::ADDR_L1_CALL)
		else $error("host call address wrong");
	a_jump_holds: assert property (JUMP_VALID && !SOFT_RESET |=> JUMP_VALID && $stable(JUMP_ADDR))
		else $error("jump dropped or moved");

	c_write: cover property (MEM_WR.valid);
	c_jump: cover property ($rose(JUMP_VALID));
	c_host: cover property (HOST_READY_FLAG);
endmodule

/* File: bml_loader_tb.sv */
/*
 Self-checking bench for the boot mode loader.
 Assumes the loader, its package, the memory model and the checker.
*/
`timescale 1ns/100ps

module bml_loader_tb;
	logic               CORE_CLK, NRST, SOFT_RESET, PREBOOT_DONE, DMA_REQUEST_ONE_N;
	logic               UART_RXD, UART_CTS, HOST_CALL_COMMAND, STREAM_READY, UART_TXD, UART_RTS_N;
	logic               FLASH_SELECT_GPIO_N, HOST_WAIT_OUT, HOST_READY_FLAG, SPI_PREAMBLE;
	logic               FIFO_WORD_TAKEN, JUMP_VALID, BOOT_IDLE, go, slow;
	logic [3:0]         BOOT_SOURCE_SELECT;
	logic [31:0]        RESET_EVENT_VECTOR, JUMP_ADDR;
	logic [7:0]         len, b;
	bml_pkg::bml_byte_s STREAM_IN;
	bml_pkg::bml_cfg_s  BOOT_CFG;
	bml_pkg::bml_wr_s   MEM_WR;
	logic [39:0]        wq[$], eq[$];
	int                 err_count, comparisons, cycles, n, p, ft;

	bml_loader dut (.CORE_CLK, .NRST, .SOFT_RESET, .BOOT_SOURCE_SELECT, .PREBOOT_DONE, .RESET_EVENT_VECTOR,
		.STREAM_IN, .STREAM_READY, .DMA_REQUEST_ONE_N, .UART_RXD, .UART_CTS, .UART_TXD, .UART_RTS_N,
		.FLASH_SELECT_GPIO_N, .HOST_WAIT_OUT, .HOST_READY_FLAG, .HOST_CALL_COMMAND, .BOOT_CFG, .MEM_WR,
		.SPI_PREAMBLE, .FIFO_WORD_TAKEN, .JUMP_VALID, .JUMP_ADDR, .BOOT_IDLE);
	bml_src_model src (.clk(CORE_CLK), .rst_n(NRST), .go, .slow, .len, .ready(STREAM_READY), .stream(STREAM_IN));

	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// Outputs launch on the rising edge, so monitors look on the falling one
	always @(negedge CORE_CLK) begin
		if (MEM_WR.valid === 1'b1) wq.push_back({MEM_WR.addr, MEM_WR.data});
		if (FIFO_WORD_TAKEN === 1'b1) ft++;
	end

	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end

	task test_done();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task cmp(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task tick(input int k);
		repeat (k) @(posedge CORE_CLK);
	endtask

	task fin(input string s);
		$display("test %s finished, mismatches %0d", s, err_count);
	endtask

	task boot(input logic [3:0] m, input logic pre);
		@(posedge CORE_CLK);
		NRST <= 1'b0;
		BOOT_SOURCE_SELECT <= m;
		PREBOOT_DONE <= pre;
		tick(2);
		NRST <= 1'b1;
		tick(6);
		@(negedge CORE_CLK);
	endtask

	task blk(input logic [31:0] a, input logic [31:0] c, input logic [31:0] f);
		logic [127:0] h;
		h = {f, c, a, 32'h0000_0000};
		for (int i = 0; i < 16; i++) src.mem[p + i] = h[8 * i +: 8];
		p += 16;
		for (int i = 0; i < c; i++) begin
			src.mem[p] = a[7:0] ^ 8'(i) ^ 8'h5A;
			eq.push_back({a + 32'(i), src.mem[p]});
			p++;
		end
	endtask

	task run(input logic [3:0] m, input logic s, input logic j);
		logic [31:0] ea;
		boot(m, 1'b1);
		p = 0;
		wq.delete();
		eq.delete();
		ea = j ? 32'h0000_3000 : RESET_EVENT_VECTOR;
		if (j) blk(32'h0000_3000, 32'h0, 32'h0000_4000);
		else begin
			blk(32'h0000_1000, 32'h3, 32'h0);
			blk(32'h0000_1800, 32'h0, 32'h0);
			blk(32'h0000_2000, 32'h2, 32'h0000_8000);
		end
		tick(1);
		slow <= s;
		len <= 8'(p);
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		for (n = 0; n < 3000 && JUMP_VALID !== 1'b1; n++) @(negedge CORE_CLK);
		repeat (3) @(negedge CORE_CLK);
		cmp(JUMP_ADDR, ea);
		cmp(wq.size(), eq.size());
		while (eq.size() > 0 && wq.size() > 0) cmp(wq.pop_front(), eq.pop_front());
		fin("stream");
	endtask

	task rx_byte(output logic [7:0] v);
		for (n = 0; n < 3000 && UART_TXD !== 1'b0; n++) @(negedge CORE_CLK);
		repeat (8) @(negedge CORE_CLK);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(negedge CORE_CLK);
			v[i] = UART_TXD;
		end
		repeat (16) @(negedge CORE_CLK);
	endtask

	initial begin
		{NRST, SOFT_RESET, PREBOOT_DONE, UART_CTS, HOST_CALL_COMMAND, go, slow} = '0;
		{DMA_REQUEST_ONE_N, UART_RXD} = 2'h3;
		BOOT_SOURCE_SELECT = 4'h0;
		RESET_EVENT_VECTOR = 32'h0000_4A00;
		len = 8'h00;
		tick(10);
		for (int m = 0; m < 16; m++) begin
			boot(m[3:0], 1'b0);
			cmp(HOST_WAIT_OUT, 1'b1);
			cmp(BOOT_CFG.source, 40'(m));
			if (m == 3) cmp(SPI_PREAMBLE, 1'b1);
			// Idle is only entered once pre-boot has finished
			tick(1);
			PREBOOT_DONE <= 1'b1;
			tick(3);
			@(negedge CORE_CLK);
			cmp(BOOT_IDLE, (m == 0 || m inside {8, 9, 11, 12, 13}));
			if (m == 4) cmp(HOST_WAIT_OUT, !STREAM_READY);
		end
		fin("modes");
		boot(bml_pkg::MODE_FLASH, 1'b0);
		tick(1);
		BOOT_SOURCE_SELECT <= bml_pkg::MODE_I2C_MEM;
		SOFT_RESET <= 1'b1;
		tick(3);
		SOFT_RESET <= 1'b0;
		tick(6);
		@(negedge CORE_CLK);
		cmp(BOOT_CFG.source, bml_pkg::MODE_I2C_MEM);
		cmp(BOOT_CFG.i2c_i2c_clock_divider, bml_pkg::I2C_I2C_CLOCK_DIVIDER);
		fin("soft reset");
		boot(bml_pkg::MODE_SPI_MEM, 1'b1);
		repeat (4) @(negedge CORE_CLK);
		cmp(FLASH_SELECT_GPIO_N, 1'b0);
		cmp(BOOT_CFG.spi_baud, bml_pkg::SPI_BAUD_DEF);
		fin("spi memory");
		run(bml_pkg::MODE_FLASH, 1'b1, 1'b0);
		run(bml_pkg::MODE_SDRAM, 1'b0, 1'b0);
		run(bml_pkg::MODE_FLASH, 1'b0, 1'b1);
		boot(bml_pkg::MODE_FIFO, 1'b1);
		ft = 0;
		repeat (2) begin
			tick(1);
			DMA_REQUEST_ONE_N <= 1'b0;
			tick(3);
			DMA_REQUEST_ONE_N <= 1'b1;
			tick(8);
		end
		cmp(ft, 2);
		fin("fifo");
		for (int m = 14; m < 16; m++) begin
			boot(m[3:0], 1'b1);
			for (n = 0; n < 200 && HOST_READY_FLAG !== 1'b1; n++) @(negedge CORE_CLK);
			cmp(HOST_READY_FLAG, 1'b1);
			cmp(BOOT_CFG.port_width, m == 14 ? bml_pkg::WIDTH_ACK16 : bml_pkg::WIDTH_INT8);
			tick(1);
			HOST_CALL_COMMAND <= 1'b1;
			for (n = 0; n < 200 && JUMP_VALID !== 1'b1; n++) @(negedge CORE_CLK);
			cmp(JUMP_ADDR, bml_pkg::ADDR_L1_CALL);
			tick(1);
			HOST_CALL_COMMAND <= 1'b0;
		end
		fin("host dma");
		boot(bml_pkg::MODE_UART, 1'b1);
		tick(1);
		UART_CTS <= 1'b1;
		// Autobaud at 16 cycles per bit; the latch holds the reload count, one less
		fork
			for (int i = 0; i < 10; i++) begin
				UART_RXD <= 1'({1'b1, bml_pkg::AB_CHAR, 1'b0} >> i);
				tick(16);
			end
			for (int k = 0; k < 4; k++) begin
				rx_byte(b);
				cmp(b, {bml_pkg::ACK_TAIL, 16'h000F, bml_pkg::ACK_HEAD} >> (8 * k) & 32'hFF);
			end
		join
		// Stop bit and one idle bit time pass before the stream opens
		repeat (40) @(negedge CORE_CLK);
		cmp(UART_RTS_N, 1'b0);
		fin("uart");
		test_done();
	end
endmodule

bind bml_loader bml_loader_chk chk (.CORE_CLK, .NRST, .SOFT_RESET, .PREBOOT_DONE, .BOOT_CFG, .MEM_WR,
	.STREAM_READY, .FLASH_SELECT_GPIO_N, .HOST_WAIT_OUT, .HOST_READY_FLAG, .JUMP_VALID, .JUMP_ADDR, .BOOT_IDLE);

/* File: bml_pkg.sv */
/*
 Package for the boot mode loader: mode codes, boot addresses, default
 peripheral settings, block header layout and the carrier structs.
 Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package bml_pkg;

	// Boot source codes on the four select pins
	localparam logic [3:0] MODE_IDLE     = 4'h0;
	localparam logic [3:0] MODE_FLASH    = 4'h1;
	localparam logic [3:0] MODE_FIFO     = 4'h2;
	localparam logic [3:0] MODE_SPI_MEM  = 4'h3;
	localparam logic [3:0] MODE_SPI_HOST = 4'h4;
	localparam logic [3:0] MODE_I2C_MEM  = 4'h5;
	localparam logic [3:0] MODE_I2C_HOST = 4'h6;
	localparam logic [3:0] MODE_UART     = 4'h7;
	localparam logic [3:0] MODE_SDRAM    = 4'hA;
	localparam logic [3:0] MODE_HDMA16   = 4'hE;
	localparam logic [3:0] MODE_HDMA8    = 4'hF;

	// Start addresses of the stream per source
	localparam logic [31:0] ADDR_FLASH   = 32'h2000_0000;
	localparam logic [31:0] ADDR_FIFO    = 32'h2030_0000;
	localparam logic [31:0] ADDR_SDRAM   = 32'h0000_0010;
	localparam logic [31:0] ADDR_L1_CALL = 32'hFFA0_0000;
	localparam logic [31:0] ADDR_ZERO    = 32'h0000_0000;

	// Default settings of the boot peripherals
	localparam logic [3:0]  FLASH_SETUP  = 4'h4;
	localparam logic [3:0]  FLASH_ACCESS = 4'hF;
	localparam logic [3:0]  FLASH_HOLD   = 4'h3;
	localparam logic [7:0]  SPI_BAUD_DEF = 8'h85;
	localparam logic [7:0]  SPI_READ_CMD = 8'h03;
	localparam logic [7:0]  SPI_ADDR_PAD = 8'h00;
	localparam logic [7:0]  I2C_MEM_ADDR = 8'hA0;
	localparam logic [6:0]  I2C_OWN_ADDR = 7'h5F;
	localparam logic [7:0]  I2C_PRESCALE = 8'h0A;
	localparam logic [15:0] I2C_I2C_CLOCK_DIVIDER   = 16'h0811;
	localparam logic [15:0] I2C_INT_ADDR = 16'h0000;
	localparam logic [1:0]  I2C_ADDR_LEN = 2'h2;

	// Autobaud and acknowledge
	localparam logic [7:0] AB_CHAR  = 8'h40;
	localparam logic [7:0] ACK_HEAD = 8'hBF;
	localparam logic [7:0] ACK_TAIL = 8'h00;
	localparam logic [1:0] ACK_LAST = 2'h3;
	// 0x40 LSB first: start plus six zero bits precede the first one
	localparam logic [3:0] AB_LOW_BITS = 4'h7;
	localparam logic [3:0] AB_LOG2     = 4'h3;

	// Block header: 16 bytes, LSB first
	localparam logic [3:0] HDR_LAST      = 4'hF;
	localparam logic [3:0] HDR_ADDR_LO   = 4'h4;
	localparam logic [3:0] HDR_COUNT_LO  = 4'h8;
	localparam logic [3:0] HDR_FLAGS_LO  = 4'hC;
	localparam int         FLG_FINAL     = 15;
	localparam int         FLG_JUMP      = 14;
	localparam int         FLG_WIDTH16   = 13;

	typedef enum logic [2:0] {
		WIDTH_NONE,
		WIDTH_8,
		WIDTH_16,
		WIDTH_ACK16,
		WIDTH_INT8
	} bml_width_e;

	// Settings handed to the boot peripheral at start of boot
	typedef struct packed {
		logic [3:0]  source;
		logic [31:0] start_addr;
		logic [7:0]  spi_baud;
		logic [7:0]  i2c_prescale;
		logic [15:0] i2c_i2c_clock_divider;
		logic [7:0]  i2c_dev_addr;
		logic [11:0] flash_timing;
		bml_width_e  port_width;
	} bml_cfg_s;

	// One byte of boot stream with its handshake
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} bml_byte_s;

	// Memory write produced by the loader
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [7:0]  data;
	} bml_wr_s;

endpackage

/* File: bml_src_model.sv */
/*
 Boot memory model: plays a byte image onto the stream port.
 Assumes the bench fills mem and pulses go; slow inserts stalls.
*/
`timescale 1ns/100ps

module bml_src_model (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          go,
	input  wire logic          slow,
	input  wire logic [7:0]    len,
	input  wire logic          ready,
	output bml_pkg::bml_byte_s stream
);
	logic [7:0] mem [0:63];
	logic [7:0] idx_q;
	logic [7:0] last_q;
	logic [1:0] gap_q;
	logic       run_q;
	wire logic  vld  = run_q & (gap_q == 2'h0);
	wire logic  take = vld & ready;

	// Released data shows the inverse of the last byte, never a stale copy
	assign stream = {vld, vld ? mem[idx_q[5:0]] : ~last_q};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			idx_q <= 8'h00;
			gap_q <= 2'h0;
			last_q <= 8'h00;
		end else if (go) begin
			run_q <= 1'b1;
			idx_q <= 8'h00;
			gap_q <= 2'h0;
		end else if (take) begin
			last_q <= stream.data;
			idx_q <= idx_q + 8'h01;
			run_q <= (idx_q + 8'h01 != len);
			gap_q <= slow ? 2'h3 : 2'h0;
		end else if (gap_q != 2'h0) begin
			gap_q <= gap_q - 2'h1;
		end
	end
endmodule
